// [logic/vtr_vector_table_relocation.sv]
// Interrupt vector placement control with timed change window
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "vtr_params.svh"

module vtr_vector_table_relocation
    import vtr_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [`VTR_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic bootResetFuse,
    input wire vtr_boot_size_fuses_t bootSizeFuses,
    input wire logic appSideBootLock,
    input wire logic bootSideSelfLock,
    input wire logic [`VTR_PC_W-1:0] fetchAddr,
    input wire logic instrRetire,
    input wire logic globalIntEnable,
    input wire logic irqPending,
    input wire logic [`VTR_IRQ_W-1:0] irqIndex,
    output logic irqTake,
    output logic interruptBlock,
    output logic [`VTR_PC_W-1:0] resetVector,
    output logic [`VTR_PC_W-1:0] vectorBase,
    output logic [`VTR_PC_W-1:0] irqVectorAddr,
    output logic vectorSelect
);

    // ****************************************
    // Reset release
    // ****************************************
    logic rstMeta_q;
    logic rstSync_n;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_q <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_n <= rstMeta_q;
        end
    end

    // ****************************************
    // Boot area start from fuses
    // ****************************************
    logic [`VTR_PC_W-1:0] bootStart;

    always_comb begin
        case (bootSizeFuses)
            2'h0: bootStart = `VTR_BOOT_2K; // see RL2
            2'h1: bootStart = `VTR_BOOT_1K;
            2'h2: bootStart = `VTR_BOOT_512;
            2'h3: bootStart = `VTR_BOOT_256;
            default: bootStart = `VTR_BOOT_2K;
        endcase
    end

    // ****************************************
    // Reset fuse capture after release
    // ****************************************
    logic fuseTaken_q;
    logic fuseTaken_d;
    logic boot_reset_fuse_q;
    logic boot_reset_fuse_d;

    always_comb begin
        fuseTaken_d = 1'b1;
        boot_reset_fuse_d = fuseTaken_q ? boot_reset_fuse_q : bootResetFuse;
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            fuseTaken_q <= 1'b0;
            boot_reset_fuse_q <= 1'b1;
        end else begin
            fuseTaken_q <= fuseTaken_d;
            boot_reset_fuse_q <= boot_reset_fuse_d;
        end
    end

    // ****************************************
    // Change window state
    // ****************************************
    vtr_state_t state_q;
    vtr_state_t state_d;
    logic [2:0] count_q;
    logic [2:0] count_d;
    logic sel_q;
    logic sel_d;
    logic gicWrite;
    logic wrChg;

    assign gicWrite = regWrite && (regAddr == `VTR_GIC_OFFSET);
    assign wrChg = regWrData[`VTR_BIT_CHG];

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        sel_d = sel_q;
        case (state_q)
            VTR_IDLE: begin
                if (gicWrite && wrChg) begin
                    state_d = VTR_OPEN; // see RL10
                    count_d = `VTR_WINDOW_CYCLES; // see RL15
                end
            end
            VTR_OPEN: begin
                if (gicWrite && wrChg) begin
                    count_d = `VTR_WINDOW_CYCLES;
                end else if (gicWrite) begin
                    sel_d = regWrData[`VTR_BIT_SEL]; // see RL10
                    state_d = VTR_POST; // see RL9
                    count_d = 3'h0;
                end else if (count_q == 3'h1) begin
                    state_d = VTR_IDLE; // see RL5
                    count_d = 3'h0;
                end else begin
                    count_d = count_q - 3'h1; // see RL9
                end
            end
            VTR_POST: begin
                if (instrRetire) begin
                    state_d = VTR_IDLE; // see RL4
                end
            end
            default: begin
                state_d = VTR_IDLE;
                count_d = 3'h0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_q <= VTR_IDLE;
            count_q <= 3'h0;
            sel_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            sel_q <= sel_d;
        end
    end

    logic chgEnable;
    assign chgEnable = (state_q == VTR_OPEN);

    // ****************************************
    // Interrupt gating
    // ****************************************
    logic inBoot;
    logic regionBlock;

    assign inBoot = (fetchAddr >= bootStart);
    always_comb begin
        regionBlock = 1'b0;
        if (sel_q && appSideBootLock == `VTR_FUSE_PROG && !inBoot) begin
            regionBlock = 1'b1; // see RL7
        end
        if (!sel_q && bootSideSelfLock == `VTR_FUSE_PROG && inBoot) begin
            regionBlock = 1'b1; // see RL8
        end
    end

    // Blocks from the enabling write cycle itself
    assign interruptBlock = (state_q != VTR_IDLE) || (state_q == VTR_IDLE && gicWrite && wrChg)
        || regionBlock; // see RL4
    // Global enable is only read, never written
    assign irqTake = irqPending && globalIntEnable && !interruptBlock; // see RL6

    // ****************************************
    // Vector addresses and read data
    // ****************************************
    logic [`VTR_PC_W-1:0] rstVec_d;
    logic [`VTR_PC_W-1:0] base_d;
    logic [`VTR_PC_W-1:0] irqAddr_d;
    logic [7:0] rdData_d;

    always_comb begin
        rstVec_d = (boot_reset_fuse_q == `VTR_FUSE_PROG) ? bootStart : `VTR_APP_RESET; // see RL11 see RL14
        base_d = (sel_q ? bootStart : `VTR_APP_RESET) + `VTR_VEC_OFFSET; // see RL1 see RL13
        // Each source sits at its normal offset from the selected table origin
        irqAddr_d = (sel_q ? bootStart : `VTR_APP_RESET) + {{(`VTR_PC_W-`VTR_IRQ_W){1'b0}}, irqIndex}; // see RL12
        rdData_d = `VTR_RD_ZERO;
        if (regRead && regAddr == `VTR_GIC_OFFSET) begin
            rdData_d[`VTR_BIT_SEL] = sel_q;
            rdData_d[`VTR_BIT_CHG] = chgEnable;
        end
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            resetVector <= `VTR_APP_RESET;
            vectorBase <= `VTR_VEC_OFFSET;
            irqVectorAddr <= `VTR_VEC_OFFSET;
            regRdData <= `VTR_RD_ZERO;
        end else begin
            resetVector <= rstVec_d;
            vectorBase <= base_d;
            irqVectorAddr <= irqAddr_d;
            regRdData <= rdData_d;
        end
    end

    assign vectorSelect = sel_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstSync_n);

    logic [3:0] openRun_q;
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            openRun_q <= 4'h0;
        end else begin
            // A restart write inside the window starts the run over
            openRun_q <= (chgEnable && !(gicWrite && wrChg)) ? openRun_q + 4'h1 : 4'h0;
        end
    end

    a_chg_opens: assert property ( // see RL10
        state_q == VTR_IDLE && gicWrite && wrChg |=> chgEnable && count_q == 3'h4)
        else $error("change enable not opened");
    a_window_limit: assert property (openRun_q <= 4'h4) // see RL9
        else $error("change window longer than four cycles");
    a_window_end: assert property ( // see RL5
        state_q == VTR_IDLE && gicWrite && wrChg ##1 !gicWrite [*4] |=> !chgEnable)
        else $error("window did not close after four cycles");
    a_sel_locked: assert property (!chgEnable |=> $stable(sel_q)) // see RL10
        else $error("select changed outside window");
    a_sel_update: assert property ( // see RL9
        chgEnable && gicWrite && !wrChg |=> sel_q == $past(regWrData[`VTR_BIT_SEL]) && !chgEnable)
        else $error("select write not taken");
    a_post_block: assert property ( // see RL4
        state_q == VTR_POST && !instrRetire |=> interruptBlock)
        else $error("interrupts released before next instruction");
    a_block_gate: assert property ((chgEnable || regionBlock) |-> !irqTake) // see RL6
        else $error("interrupt taken while blocked");
    a_reset_vec: assert property ( // see RL11
        fuseTaken_q && boot_reset_fuse_q == `VTR_FUSE_PROG |=> resetVector == $past(bootStart))
        else $error("reset vector not at boot start");
    a_vec_base: assert property ( // see RL13
        sel_q |=> vectorBase == $past(bootStart) + `VTR_VEC_OFFSET)
        else $error("relocated table base wrong");
    a_app_lock: assert property ( // see RL7
        sel_q && appSideBootLock == `VTR_FUSE_PROG && !inBoot |-> interruptBlock)
        else $error("app area not blocked");

    // ****************************************
    // Region, blocking, window, vector, fuse and read checks
    // ****************************************
    a_boot_lock: assert property ( // see RL8
        !sel_q && bootSideSelfLock == `VTR_FUSE_PROG && inBoot |-> interruptBlock)
        else $error("boot area not blocked");
    a_chg_block: assert property ( // see RL4
        state_q == VTR_IDLE && gicWrite && wrChg |-> interruptBlock)
        else $error("enabling write cycle not blocked");
    a_post_release: assert property ( // see RL4
        state_q == VTR_POST && instrRetire |=> state_q == VTR_IDLE)
        else $error("block not released after next instruction");
    a_irq_addr: assert property ( // see RL12
        sel_q |=> irqVectorAddr == $past(bootStart) + {{(`VTR_PC_W-`VTR_IRQ_W){1'b0}}, $past(irqIndex)})
        else $error("relocated vector address wrong");
    a_app_vec: assert property ( // see RL1
        !sel_q |=> vectorBase == `VTR_VEC_OFFSET)
        else $error("application table base wrong");

    a_rd_zero: assert property ( // see RL10
        regRead && regAddr != `VTR_GIC_OFFSET |=> regRdData == `VTR_RD_ZERO)
        else $error("unmapped read not zero");
    a_app_reset: assert property ( // see RL14
        fuseTaken_q && boot_reset_fuse_q != `VTR_FUSE_PROG |=> resetVector == `VTR_APP_RESET)
        else $error("reset vector not at zero");
    a_irq_take: assert property ( // see RL6
        irqPending && globalIntEnable && !interruptBlock |-> irqTake)
        else $error("open interrupt not taken");
    a_fuse_hold: assert property ( // see RL14
        fuseTaken_q |=> $stable(boot_reset_fuse_q))
        else $error("reset fuse copy changed after capture");
    a_sel_read: assert property ( // see RL10
        regRead && regAddr == `VTR_GIC_OFFSET |=> regRdData[`VTR_BIT_SEL] == $past(sel_q)
        && regRdData[`VTR_BIT_CHG] == $past(chgEnable))
        else $error("control read data wrong");
    a_timeout_clear: assert property ( // see RL9
        chgEnable && count_q == 3'h1 && !gicWrite |=> !chgEnable)
        else $error("change enable not cleared on timeout");

    // ****************************************
    // Covers
    // ****************************************
    c_move_boot: cover property (chgEnable && gicWrite && regWrData[`VTR_BIT_SEL]);
    c_timeout: cover property (chgEnable && count_q == 3'h1 && !gicWrite);
    c_region: cover property (regionBlock && irqPending);
    c_move_app: cover property (chgEnable && gicWrite && !wrChg && !regWrData[`VTR_BIT_SEL]);
    c_restart: cover property (chgEnable && gicWrite && wrChg);

endmodule : vtr_vector_table_relocation

// [logic/vtr_params.svh]
// Constants of the vector table relocation block
// Function
// (RL1) Vector select zero puts vectors at flash start, one at boot area start.
// (RL2) Boot area start address comes from the boot size fuses.
// (RL3) Software sets change enable, then writes select within four cycles.
// (RL4) Interrupts blocked from change enable set until after next instruction.
// (RL5) Without a select write, interrupts stay blocked four cycles.
// (RL6) Automatic blocking never alters the global interrupt enable flag.
// (RL7) Boot vectors and app-side lock block interrupts in the application area.
// (RL8) App vectors and boot-side lock block interrupts in the boot area.
// (RL9) Change enable clears after four cycles or when select is written.
// (RL10) Select changes only while change enable is set; enable opens window.
// (RL11) Programmed boot reset fuse with 2K boot area resets to word c00.
// (RL12) 2K boot area with select set puts vectors at c01 through c12.
// (RL13) Relocated vector equals boot reset address plus normal offset.
// (RL14) Boot reset fuse reads one unprogrammed, zero programmed.
// (RL15) Window counted in system clocks, started by enable write, reset cleared.
`ifndef VTR_PARAMS_SVH
`define VTR_PARAMS_SVH

// ****************************************
// Register map and fields
// ****************************************
`define VTR_ADDR_W 6
`define VTR_GIC_OFFSET 6'h3b
`define VTR_BIT_CHG 0
`define VTR_BIT_SEL 1
`define VTR_GIC_RESET 8'h00
`define VTR_RD_ZERO 8'h00

// ****************************************
// Timing and addresses
// ****************************************
`define VTR_WINDOW_CYCLES 3'h4
`define VTR_PC_W 12
`define VTR_APP_RESET 12'h000
`define VTR_VEC_OFFSET 12'h001
`define VTR_BOOT_2K 12'hc00
`define VTR_BOOT_1K 12'he00
`define VTR_BOOT_512 12'hf00
`define VTR_BOOT_256 12'hf80
`define VTR_IRQ_W 5
`define VTR_FUSE_PROG 1'b0

`endif

// [logic/vtr_pkg.sv]
// Types of the vector table relocation block
package vtr_pkg;
    typedef enum logic [1:0] {
        VTR_IDLE,
        VTR_OPEN,
        VTR_POST
    } vtr_state_t;
    typedef logic [1:0] vtr_boot_size_fuses_t;
endpackage : vtr_pkg

// [test/vtr_core_model.sv]
// Behavioural core model: fetch address, retire pulses and interrupt requests
`timescale 1ns/1ps
`include "vtr_params.svh"
module vtr_core_model (
    input wire logic clock,
    input wire logic [`VTR_PC_W-1:0] pcIn,
    input wire logic retireIn,
    input wire logic gieIn,
    input wire logic irqIn,
    input wire logic [`VTR_IRQ_W-1:0] idxIn,
    output logic [`VTR_PC_W-1:0] fetchAddr,
    output logic instrRetire,
    output logic globalIntEnable,
    output logic irqPending,
    output logic [`VTR_IRQ_W-1:0] irqIndex
);
    // Core state moves one clock behind the commands it is given
    always @(posedge clock) begin
        fetchAddr <= pcIn;
        instrRetire <= retireIn;
        globalIntEnable <= gieIn;
        irqPending <= irqIn;
        irqIndex <= idxIn;
    end
endmodule : vtr_core_model

// [test/vtr_vector_table_relocation_test.sv]
// Self-checking bench for the vector table relocation block
`timescale 1ns/1ps
`include "vtr_params.svh"
module vtr_vector_table_relocation_test;
    import vtr_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, bootResetFuse = `VTR_FUSE_PROG;
    logic [`VTR_ADDR_W-1:0] regAddr = `VTR_GIC_OFFSET;
    logic [7:0] regWrData = 8'h00, regRdData, lfsr = 8'h62;
    vtr_boot_size_fuses_t bootSizeFuses = 2'h0;
    logic appSideBootLock = 1'b1, bootSideSelfLock = 1'b1, retireIn = 1'b0, gieIn = 1'b0, irqIn = 1'b0;
    logic instrRetire, globalIntEnable, irqPending, irqTake, interruptBlock, vectorSelect;
    logic rdPend = 1'b0, selExp = 1'b0, checking = 1'b0;
    logic [`VTR_PC_W-1:0] fetchAddr, resetVector, vectorBase, irqVectorAddr, pcIn = 12'h010;
    logic [`VTR_PC_W-1:0] vaExp = 12'h000, vbExp = 12'h000;
    logic [`VTR_IRQ_W-1:0] irqIndex, idxIn = 5'h01;
    logic [7:0] rdQ[$];
    int fails = 0;
    int samples_checked = 0;

    always #25 clock = ~clock;

    vtr_vector_table_relocation dut (.clock, .reset_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
        .bootResetFuse, .bootSizeFuses, .appSideBootLock, .bootSideSelfLock, .fetchAddr, .instrRetire,
        .globalIntEnable, .irqPending, .irqIndex, .irqTake, .interruptBlock, .resetVector, .vectorBase,
        .irqVectorAddr, .vectorSelect);
    vtr_core_model core (.clock, .pcIn, .retireIn, .gieIn, .irqIn, .idxIn, .fetchAddr, .instrRetire,
        .globalIntEnable, .irqPending, .irqIndex);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] next_rand(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : next_rand
    function automatic logic [11:0] boot_start(input vtr_boot_size_fuses_t s);
        case (s)
            2'h0: return `VTR_BOOT_2K;
            2'h1: return `VTR_BOOT_1K;
            2'h2: return `VTR_BOOT_512;
            default: return `VTR_BOOT_256;
        endcase
    endfunction : boot_start
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        if (fails == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [7:0] d);
        @(posedge clock);
        regAddr <= `VTR_GIC_OFFSET;
        regWrData <= d;
        regRead <= 1'b0;
        regWrite <= 1'b1;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clock);
        regAddr <= a;
        regWrite <= 1'b0;
        regRead <= 1'b1;
        rdQ.push_back(exp);
    endtask : rd
    task automatic step(input int k);
        repeat (k) begin
            @(posedge clock);
            regWrite <= 1'b0;
            regRead <= 1'b0;
        end
    endtask : step
    task automatic look(input logic exp);
        @(negedge clock);
        check(12'(interruptBlock), 12'(exp));
        check(12'(irqTake), 12'(irqPending && globalIntEnable && !exp));
        step(1);
    endtask : look
    task automatic retire();
        @(posedge clock);
        retireIn <= 1'b1;
        repeat (2) @(posedge clock);
        retireIn <= 1'b0;
    endtask : retire

    // ****************************************
    // Random requests and output monitor
    // ****************************************
    always @(posedge clock) begin
        lfsr <= next_rand(lfsr);
        gieIn <= lfsr[0];
        irqIn <= lfsr[1];
        idxIn <= 5'(lfsr % 18 + 1);
        rdPend <= regRead;
        if (rdPend) check(12'(regRdData), 12'(rdQ.pop_front()));
        if (checking) begin
            check(vectorBase, vbExp);
            check(irqVectorAddr, vaExp);
            check(12'(vectorSelect), 12'(selExp));
        end
        vbExp <= (selExp ? boot_start(bootSizeFuses) : `VTR_APP_RESET) + `VTR_VEC_OFFSET;
        vaExp <= (selExp ? boot_start(bootSizeFuses) : `VTR_APP_RESET) + 12'(irqIndex);
    end

    initial begin
        repeat (3000) @(posedge clock);
        fails++;
        print_verdict();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        step(5);
        checking <= 1'b1;
        check(resetVector, `VTR_BOOT_2K);
        rd(`VTR_GIC_OFFSET, `VTR_GIC_RESET);
        rd(6'h3a, `VTR_RD_ZERO);
        wr(8'h02);
        rd(`VTR_GIC_OFFSET, 8'h00);
        wr(8'h01);
        step(2);
        look(1'b1);
        rd(`VTR_GIC_OFFSET, 8'h01);
        rd(`VTR_GIC_OFFSET, 8'h00);
        look(1'b0);
        wr(8'h01);
        wr(8'h01);
        step(4);
        look(1'b1);
        look(1'b0);
        for (int s = 0; s < 4; s++) begin
            bootSizeFuses <= 2'(s);
            wr(8'h01);
            wr(8'h02);
            rd(`VTR_GIC_OFFSET, 8'h02);
            selExp <= 1'b1;
            step(6);
            look(1'b1);
            retire();
            look(1'b0);
            appSideBootLock <= 1'b0;
            step(2);
            look(1'b1);
            pcIn <= boot_start(2'(s)) + 12'h005;
            step(2);
            look(1'b0);
            appSideBootLock <= 1'b1;
            wr(8'h01);
            wr(8'h00);
            step(1);
            selExp <= 1'b0;
            retire();
            look(1'b0);
            bootSideSelfLock <= 1'b0;
            step(2);
            look(1'b1);
            bootSideSelfLock <= 1'b1;
            pcIn <= 12'h010;
        end
        checking <= 1'b0;
        bootResetFuse <= 1'b1;
        reset_n <= 1'b0;
        step(2);
        reset_n <= 1'b1;
        step(5);
        check(resetVector, `VTR_APP_RESET);
        print_verdict();
    end
endmodule : vtr_vector_table_relocation_test
